// >>> verilog/dbmp_ddr_burst_memory_port.v
// Function
// - Two write data words move per write-clock period; read data moves one word per system clock.
// - Read data launched on system clock, not on free-running data clock.
// - Commands sampled on command clock rising edge.
// - Write data captured on both write-clock edges.
// - Every access transfers a burst of words.
// - Burst length 2, 4 or 8 from mode.
// - Refresh row address generated inside device.
// - Eight banks, one access at a time, no overlap.
// - Write mask leaves masked words unwritten.
`timescale 1ns/1ps
`default_nettype none
`include "dbmp_consts.vh"
module dbmp_ddr_burst_memory_port (
  input  wire                      i_clk_sys,
  input  wire                      i_rst_n,
  input  wire                      i_command_input_clock,
  input  wire [2:0]                i_cmd,
  input  wire [`DBMP_BANK_W-1:0]   i_bank,
  input  wire [`DBMP_ADDR_W-1:0]   i_addr,
  input  wire                      i_write_data_clock,
  input  wire [`DBMP_DW-1:0]       i_wdata,
  input  wire                      i_write_mask_input,
  input  wire                      i_rd_ready,
  output reg                       o_qclk,
  output reg  [`DBMP_DW-1:0]       o_rdata,
  output reg                       o_rvalid,
  output reg                       o_busy
);
  localparam DEPTH = 1 << (`DBMP_BANK_W + `DBMP_ROW_W + `DBMP_COL_W);
  localparam ST_IDLE = 2'h0;
  localparam ST_WR   = 2'h1;
  localparam ST_RD   = 2'h2;
  localparam ST_REF  = 2'h3;

  reg [`DBMP_DW-1:0] mem [0:DEPTH-1];
  reg [2:0] ck_s_q;
  reg [2:0] dk_s_q;
  reg [2:0] cmd_s1_q, cmd_s2_q;
  reg [`DBMP_BANK_W-1:0] bank_s1_q, bank_s2_q;
  reg [`DBMP_ADDR_W-1:0] addr_s1_q, addr_s2_q;
  reg [`DBMP_DW-1:0] wd_s1_q, wd_s2_q;
  reg wm_s1_q, wm_s2_q;
  reg [1:0] st_q;
  reg [1:0] bl_q;
  reg [3:0] cnt_q;
  reg [3:0] len_q;
  reg [`DBMP_BANK_W-1:0] bk_q;
  reg [`DBMP_ROW_W-1:0] row_q;
  reg [`DBMP_COL_W-1:0] col_q;
  reg [3:0] qdiv_q;
  reg [`DBMP_DW-1:0] buf_q [0:1];
  reg [1:0] bcnt_q;
  reg bwp_q, brp_q;

  wire ck_rise = ck_s_q[1] & ~ck_s_q[2];
  wire dk_edge = dk_s_q[1] ^ dk_s_q[2];
  wire [3:0] bl_len = (bl_q == `DBMP_BL_8) ? 4'h8 :
                      (bl_q == `DBMP_BL_4) ? 4'h4 : 4'h2;
  wire [`DBMP_BANK_W+`DBMP_ROW_W+`DBMP_COL_W-1:0] wa = {bk_q, row_q, col_q};
  wire buf_ready = (bcnt_q != 2'h2);
  wire buf_push  = (st_q == ST_RD) & buf_ready;
  wire buf_pop   = (bcnt_q != 2'h0) & (~o_rvalid | i_rd_ready);

  // Synchronisers; the first stage feeds only the second.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ck_s_q    <= 3'h0;
      dk_s_q    <= 3'h0;
      cmd_s1_q  <= 3'h0;
      cmd_s2_q  <= 3'h0;
      bank_s1_q <= {`DBMP_BANK_W{1'b0}};
      bank_s2_q <= {`DBMP_BANK_W{1'b0}};
      addr_s1_q <= {`DBMP_ADDR_W{1'b0}};
      addr_s2_q <= {`DBMP_ADDR_W{1'b0}};
      wd_s1_q   <= {`DBMP_DW{1'b0}};
      wd_s2_q   <= {`DBMP_DW{1'b0}};
      wm_s1_q   <= 1'b0;
      wm_s2_q   <= 1'b0;
    end else begin
      ck_s_q    <= {ck_s_q[1:0], i_command_input_clock};
      dk_s_q    <= {dk_s_q[1:0], i_write_data_clock};
      cmd_s1_q  <= i_cmd;
      cmd_s2_q  <= cmd_s1_q;
      bank_s1_q <= i_bank;
      bank_s2_q <= bank_s1_q;
      addr_s1_q <= i_addr;
      addr_s2_q <= addr_s1_q;
      wd_s1_q   <= i_wdata;
      wd_s2_q   <= wd_s1_q;
      wm_s1_q   <= i_write_mask_input;
      wm_s2_q   <= wm_s1_q;
    end
  end

  // Free-running read data clock divided from the system clock.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      qdiv_q <= 4'h0;
      o_qclk <= 1'b0;
    end else if (qdiv_q == `DBMP_QCLK_HALF - 4'h1) begin
      qdiv_q <= 4'h0;
      o_qclk <= ~o_qclk;
    end else begin
      qdiv_q <= qdiv_q + 4'h1;
    end
  end

  // Command decode and burst sequencer.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q   <= ST_IDLE;
      bl_q   <= `DBMP_BL_RST;
      cnt_q  <= 4'h0;
      len_q  <= 4'h0;
      bk_q   <= {`DBMP_BANK_W{1'b0}};
      row_q  <= {`DBMP_ROW_W{1'b0}};
      col_q  <= {`DBMP_COL_W{1'b0}};
      o_busy <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (ck_rise) begin
            bk_q  <= bank_s2_q;
            row_q <= addr_s2_q[`DBMP_COL_W+`DBMP_ROW_W-1:`DBMP_COL_W];
            col_q <= addr_s2_q[`DBMP_COL_W-1:0];
            cnt_q <= 4'h0;
            len_q <= bl_len;
            case (cmd_s2_q)
              `DBMP_CMD_MRS: begin
                if (addr_s2_q[1:0] != 2'h3)
                  bl_q <= addr_s2_q[1:0];
              end
              `DBMP_CMD_WR: begin
                st_q   <= ST_WR;
                o_busy <= 1'b1;
              end
              `DBMP_CMD_RD: begin
                st_q   <= ST_RD;
                o_busy <= 1'b1;
              end
              `DBMP_CMD_REF: begin
                st_q   <= ST_REF;
                o_busy <= 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        ST_WR: begin
          if (dk_edge) begin
            col_q <= col_q + {{(`DBMP_COL_W-1){1'b0}}, 1'b1};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == len_q - 4'h1) begin
              st_q   <= ST_IDLE;
              o_busy <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (buf_ready) begin
            col_q <= col_q + {{(`DBMP_COL_W-1){1'b0}}, 1'b1};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == len_q - 4'h1) begin
              st_q   <= ST_IDLE;
              o_busy <= 1'b0;
            end
          end
        end
        ST_REF: begin
          st_q   <= ST_IDLE;
          o_busy <= 1'b0;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Array writes, masked words are skipped.
  always @(posedge i_clk_sys) begin
    if (st_q == ST_WR && dk_edge && !wm_s2_q)
      mem[wa] <= wd_s2_q;
  end

  // Per-bank internal refresh row counters, one process each so that
  // every counter has a single driver.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ref
      localparam [`DBMP_BANK_W-1:0] BANK = gi;
      reg [`DBMP_ROW_W-1:0] row_ctr_q;
      always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n)
          row_ctr_q <= {`DBMP_ROW_W{1'b0}};
        else if (st_q == ST_REF && bk_q == BANK)
          row_ctr_q <= row_ctr_q + {{(`DBMP_ROW_W-1){1'b0}}, 1'b1};
      end
    end
  endgenerate

  // Two-entry read buffer and output register.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bcnt_q   <= 2'h0;
      bwp_q    <= 1'b0;
      brp_q    <= 1'b0;
      o_rdata  <= {`DBMP_DW{1'b0}};
      o_rvalid <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_q[bwp_q] <= mem[wa];
        bwp_q        <= ~bwp_q;
      end
      if (buf_pop) begin
        o_rdata  <= buf_q[brp_q];
        brp_q    <= ~brp_q;
        o_rvalid <= 1'b1;
      end else if (i_rd_ready) begin
        o_rvalid <= 1'b0;
      end
      bcnt_q <= bcnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end
endmodule
`default_nettype wire

// >>> verilog/dbmp_consts.vh
`ifndef DBMP_CONSTS_VH
`define DBMP_CONSTS_VH
// Data word width and array organisation.
`define DBMP_DW         8
`define DBMP_BANK_W     3
`define DBMP_ROW_W      4
`define DBMP_COL_W      3
`define DBMP_ADDR_W     10
// Burst length codes held in the mode register.
`define DBMP_BL_2       2'h0
`define DBMP_BL_4       2'h1
`define DBMP_BL_8       2'h2
`define DBMP_BL_RST     2'h0
// Command encodings on the command pins.
`define DBMP_CMD_NOP    3'h0
`define DBMP_CMD_MRS    3'h1
`define DBMP_CMD_WR     3'h2
`define DBMP_CMD_RD     3'h3
`define DBMP_CMD_REF    3'h4
// Read data clock divider: half period in system clocks.
`define DBMP_QCLK_HALF  4'h4
`endif

// >>> test/dbmp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dbmp_checker (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic       i_command_input_clock,
  input wire logic [2:0] i_cmd,
  input wire logic       i_rd_ready,
  input wire logic       o_qclk,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rvalid,
  input wire logic       o_busy
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  qclk_hi_a: assert property (
    $rose(o_qclk) |-> o_qclk [*4] ##1 !o_qclk)
    else $error("read clock high phase wrong");
  qclk_lo_a: assert property (
    $fell(o_qclk) |-> !o_qclk [*4] ##1 o_qclk)
    else $error("read clock low phase wrong");
  rvalid_hold_a: assert property (
    o_rvalid && !i_rd_ready |=> o_rvalid)
    else $error("read word dropped");
  rdata_hold_a: assert property (
    o_rvalid && !i_rd_ready |=> $stable(o_rdata))
    else $error("read word changed");
  rvalid_drop_a: assert property (
    $fell(o_rvalid) |-> $past(i_rd_ready))
    else $error("read word left untaken");
  busy_cause_a: assert property (
    $rose(o_busy) |-> $past(i_command_input_clock, 3))
    else $error("busy without command clock rise");
  busy_min_a: assert property (
    $rose(o_busy) && i_cmd != 3'h4 |=> o_busy)
    else $error("burst too short");
  rvalid_src_a: assert property (
    $rose(o_rvalid) |->
    o_busy || $past(o_busy) || $past(o_busy, 2) || $past(o_busy, 3))
    else $error("read word without burst");
endmodule
bind dbmp_ddr_burst_memory_port dbmp_checker u_chk (.i_clk_sys, .i_rst_n,
  .i_command_input_clock, .i_cmd, .i_rd_ready, .o_qclk, .o_rdata, .o_rvalid,
  .o_busy);
`default_nettype wire

// >>> test/dbmp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbmp_ctrl_model (
  input  wire logic       i_clk_sys,
  output var  logic       o_dk = 1'b0,
  output var  logic [7:0] o_wdata = 8'h00,
  output var  logic       o_mask = 1'b0
);
  // Sends n words, one per data clock edge; each word settles one cycle
  // before its edge, and the clock stands still between bursts.
  task automatic burst(input int n, input logic [7:0] b, input int mi);
    for (int k = 0; k < n; k++) begin
      o_wdata = b + k[7:0];
      o_mask = (k == mi);
      @(posedge i_clk_sys);
      #1 o_dk = ~o_dk;
      repeat (3) @(posedge i_clk_sys);
      #1;
    end
    o_wdata = ~o_wdata;
    o_mask = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbmp_consts.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  err_count++; $display("ERROR %s exp %h got %h", n, e, a); end end
module testbench;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_command_input_clock = 1'b0;
  logic [2:0] i_cmd = 3'h0, i_bank = 3'h0;
  logic [9:0] i_addr = 10'h000;
  logic i_rd_ready = 1'b0;
  wire logic i_write_data_clock, i_write_mask_input, o_qclk, o_rvalid, o_busy;
  wire logic [7:0] i_wdata, o_rdata;
  logic [7:0] mem [0:1023];
  int err_count = 0;
  int samples_checked = 0;
  // System clock.
  always #12.5 i_clk_sys = ~i_clk_sys;
  dbmp_ddr_burst_memory_port dut (.i_clk_sys, .i_rst_n, .i_command_input_clock,
    .i_cmd, .i_bank, .i_addr, .i_write_data_clock, .i_wdata,
    .i_write_mask_input, .i_rd_ready, .o_qclk, .o_rdata, .o_rvalid, .o_busy);
  dbmp_ctrl_model ctl (.i_clk_sys, .o_dk(i_write_data_clock),
    .o_wdata(i_wdata), .o_mask(i_write_mask_input));
  // Command set up one cycle ahead, then one command clock period of 200 ns.
  task automatic issue(input logic [2:0] c, b, input logic [9:0] a);
    i_cmd = c;
    i_bank = b;
    i_addr = a;
    @(posedge i_clk_sys);
    #1 i_command_input_clock = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1 i_command_input_clock = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    #1 i_cmd = `DBMP_CMD_NOP;
    // Bursts end on their own data; only short commands are waited out.
    for (int t = 0; c != `DBMP_CMD_WR && c != `DBMP_CMD_RD &&
         o_busy === 1'b1 && t < 400; t++) begin
      @(posedge i_clk_sys);
      #1;
    end
  endtask
  // Write burst, recording what the array should now hold.
  task automatic wr(input logic [2:0] b, input logic [9:0] a, input int n,
                    input logic [7:0] d, input int mi);
    issue(`DBMP_CMD_WR, b, a);
    ctl.burst(n, d, mi);
    repeat (20) @(posedge i_clk_sys);
    #1 `CHK("busy", 1'b0, o_busy)
    for (int k = 0; k < n; k++)
      if (k != mi) mem[{b, a[6:3], a[2:0] + k[2:0]}] = d + k[7:0];
  endtask
  // Read burst taken late; each word is judged mid-cycle while it stands
  // and is then taken at the next rising edge; no extra word follows.
  task automatic rd(input logic [2:0] b, input logic [9:0] a, input int n);
    int t;
    issue(`DBMP_CMD_RD, b, a);
    repeat (10) @(posedge i_clk_sys);
    #1 i_rd_ready = 1'b1;
    for (int k = 0; k < n; k++) begin
      t = 0;
      do @(negedge i_clk_sys); while (o_rvalid !== 1'b1 && ++t < 200);
      `CHK("rvalid", 1'b1, o_rvalid)
      `CHK("rdata", mem[{b, a[6:3], a[2:0] + k[2:0]}], o_rdata)
      @(posedge i_clk_sys);
    end
    #1 i_rd_ready = 1'b0;
    repeat (20) @(posedge i_clk_sys);
    #1 `CHK("extra word", 1'b0, o_rvalid)
  endtask
  // Every length code, the last one reserved and ignored.
  task automatic t_lengths();
    for (int c = 0; c < 4; c++) begin
      issue(`DBMP_CMD_MRS, 3'h0, {8'h00, c[1:0]});
      wr(c[2:0], 10'h02E, 2 << (c > 2 ? 2 : c), 8'h10 * c[7:0], -1);
      rd(c[2:0], 10'h02E, 2 << (c > 2 ? 2 : c));
    end
  endtask
  // Masked overwrite, refresh, then both banks keep their data.
  task automatic t_mask_ref();
    wr(3'h5, 10'h010, 8, 8'hA0, -1);
    wr(3'h5, 10'h010, 8, 8'hC0, 3);
    issue(`DBMP_CMD_REF, 3'h5, 10'h3FF);
    rd(3'h5, 10'h010, 8);
    rd(3'h2, 10'h02E, 8);
  endtask
  // Read data clock: each phase lasts the divider's half period.
  task automatic t_qclk();
    int t;
    t = 0;
    do @(negedge i_clk_sys); while (o_qclk !== 1'b0 && ++t < 40);
    do @(negedge i_clk_sys); while (o_qclk !== 1'b1 && ++t < 40);
    t = 0;
    do begin
      @(negedge i_clk_sys);
      t++;
    end while (o_qclk === 1'b1 && t < 40);
    `CHK("qclk high", `DBMP_QCLK_HALF, t[3:0])
    t = 0;
    do begin
      @(negedge i_clk_sys);
      t++;
    end while (o_qclk === 1'b0 && t < 40);
    `CHK("qclk low", `DBMP_QCLK_HALF, t[3:0])
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard, far above the run length.
  initial begin
    #400us;
    err_count++;
    summarize();
  end
  // Reset for 12 cycles, then the scenarios.
  initial begin
    repeat (12) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1;
    t_qclk();
    t_lengths();
    t_mask_ref();
    summarize();
  end
endmodule
`default_nettype wire
